/* rtl/fesr_fault_records.sv */
// Fault manager error records: collects safety-check errors, logs them per block and drives
// the recovery and fault-handling interrupt levels.
// Assumes all inputs synchronous to clk_in; both register ports follow the one-cycle strobe protocol.
//
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/1ps
module fesr_fault_records (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic fm_reset_in,
    input wire fesr_pkg::fesr_bus_req_s fm_bus_in,
    output logic [fesr_pkg::DATA_W-1:0] fm_rdata_out,
    input wire fesr_pkg::fesr_bus_req_s main_bus_in,
    output logic [fesr_pkg::DATA_W-1:0] main_rdata_out,
    input wire fesr_pkg::fesr_report_s stream_report_in,
    input wire logic [fesr_pkg::BUF_UNITS-1:0] buf_err_wire_in,
    input wire logic [fesr_pkg::CTL_CHECKS-1:0] ctl_check_in,
    input wire logic [fesr_pkg::SIDE_CHANNELS-1:0] side_err_in,
    output logic recovery_interrupt_out,
    output logic fault_handling_interrupt_out,
    output logic [fesr_pkg::RECORDS-1:0] unit_err_out,
    output logic locked_out
);

    localparam int RECORDS = fesr_pkg::RECORDS;
    localparam int ID_W = fesr_pkg::ID_W;
    localparam int CHK_W = fesr_pkg::CHK_W;
    localparam int SRC_W = fesr_pkg::SRC_W;
    localparam int SYN_W = fesr_pkg::SYN_W;
    localparam int DATA_W = fesr_pkg::DATA_W;

    fesr_pkg::fesr_state_s state_q;
    fesr_pkg::fesr_state_s state_d;

    // Fault-manager port decode
    logic fm_rec_ok;
    logic [ID_W-1:0] fm_idx;
    logic [3:0] fm_ofs;
    logic fm_wr_ok;

    assign fm_idx = fm_bus_in.addr[9:4];
    assign fm_ofs = fm_bus_in.addr[3:0];
    assign fm_rec_ok = (fm_bus_in.addr[11:10] == fesr_pkg::REC_AREA) && (fm_idx < ID_W'(RECORDS));
    assign fm_wr_ok = fm_bus_in.wr && fm_rec_ok && !state_q.locked;

    // Per-record event evaluation
    logic [RECORDS-1:0] hit;
    logic [RECORDS-1:0] ram_chk;
    logic [RECORDS-1:0] first;
    logic [RECORDS-1:0] rec_valid;
    logic [RECORDS-1:0] rec_recovery;
    logic [RECORDS-1:0] rec_fault;
    logic [RECORDS-1:0][CHK_W-1:0] chk;
    logic [RECORDS-1:0][SRC_W-1:0] src;
    fesr_pkg::fesr_rec_sts_s [RECORDS-1:0] sts_next;
    fesr_pkg::fesr_rec_ctl_s [RECORDS-1:0] ctl_next;

    logic [ID_W-1:0] ctl_low;
    logic [ID_W-1:0] side_low;

    assign ctl_low = fesr_pkg::lowest_index(64'(ctl_check_in));
    assign side_low = fesr_pkg::lowest_index(64'(side_err_in));

    genvar r;
    generate
        for (r = 0; r < RECORDS; r++)
        begin : g_rec
            logic log_en;
            logic ue_log;
            logic clr;
            logic wr_ctl;
            logic stream_hit;
            logic wire_hit;

            if (r == fesr_pkg::REC_CTL)
            begin : g_ctl
                // Control unit checks land in record 0
                assign stream_hit = 1'b0;
                assign wire_hit = 1'b0;
                assign hit[r] = |ctl_check_in;
                assign chk[r] = ctl_low[CHK_W-1:0];
                assign src[r] = fesr_pkg::SRC_CTL;
                assign ram_chk[r] = fesr_pkg::in_range(ctl_low[CHK_W-1:0], fesr_pkg::CTL_RAM_LO,
                                                       fesr_pkg::CTL_RAM_HI);
            end
            else if (r == fesr_pkg::REC_SIDE)
            begin : g_side
                // Shared record of all side channels; channel number is kept as check number
                assign stream_hit = 1'b0;
                assign wire_hit = 1'b0;
                assign hit[r] = |side_err_in;
                assign chk[r] = side_low[CHK_W-1:0];
                assign src[r] = fesr_pkg::SRC_SIDE;
                assign ram_chk[r] = 1'b0;
            end
            else
            begin : g_buf
                assign stream_hit = stream_report_in.valid
                                    && (stream_report_in.block_id == ID_W'(r));
                // Redundant wire only logs when no genuine uncorrected error is already held
                assign wire_hit = buf_err_wire_in[r - fesr_pkg::REC_BUF_BASE]
                                  && !(state_q.sts[r].valid && state_q.sts[r].real_ue);
                assign hit[r] = stream_hit || wire_hit;
                assign chk[r] = stream_hit ? stream_report_in.check : fesr_pkg::UNKNOWN_CHECK;
                assign src[r] = stream_hit ? fesr_pkg::SRC_STREAM : fesr_pkg::SRC_WIRE;
                assign ram_chk[r] = stream_hit && fesr_pkg::in_range(stream_report_in.check,
                                                                     fesr_pkg::BUF_RAM_LO,
                                                                     fesr_pkg::BUF_RAM_HI);
            end

            assign log_en = hit[r] && state_q.ctl[r].ed;
            assign ue_log = !ram_chk[r] || state_q.ctl[r].ce_en;
            assign clr = fm_wr_ok && (fm_idx == ID_W'(r)) && (fm_ofs == fesr_pkg::REC_STATUS_OFS)
                         && fm_bus_in.wdata[fesr_pkg::STS_VALID_BIT];
            assign wr_ctl = fm_wr_ok && (fm_idx == ID_W'(r)) && (fm_ofs == fesr_pkg::REC_CTL_OFS);

            // New error wins over a clear in the same cycle
            always_comb
            begin
                sts_next[r] = state_q.sts[r];
                if (clr)
                begin
                    sts_next[r] = '0;
                end
                if (log_en)
                begin
                    sts_next[r].valid = 1'b1;
                    sts_next[r].ue = sts_next[r].ue || ue_log;
                    sts_next[r].real_ue = sts_next[r].real_ue || !ram_chk[r];
                end
            end

            always_comb
            begin
                ctl_next[r] = state_q.ctl[r];
                if (wr_ctl)
                begin
                    ctl_next[r].ed = fm_bus_in.wdata[fesr_pkg::CTL_ED_BIT];
                    ctl_next[r].ui = fm_bus_in.wdata[fesr_pkg::CTL_UI_BIT];
                    ctl_next[r].fi = fm_bus_in.wdata[fesr_pkg::CTL_FI_BIT];
                    ctl_next[r].ce_en = fm_bus_in.wdata[fesr_pkg::CTL_CE_EN_BIT];
                end
            end

            assign first[r] = log_en && (!state_q.sts[r].valid || clr);
            assign rec_valid[r] = state_q.sts[r].valid;
            assign unit_err_out[r] = state_q.sts[r].valid && state_q.sts[r].real_ue;
            assign rec_recovery[r] = state_q.sts[r].valid && state_q.sts[r].ue
                                     && state_q.ctl[r].ui;
            assign rec_fault[r] = state_q.sts[r].valid && state_q.ctl[r].fi;
        end
    endgenerate

    assign recovery_interrupt_out = |rec_recovery;
    assign fault_handling_interrupt_out = |rec_fault;

    // Syndrome capture: the lowest record that newly turns valid is written this cycle
    logic [ID_W-1:0] syn_idx;
    logic [SYN_W-1:0] syn_wdata;
    logic [SYN_W-1:0] syn_rdata;

    assign syn_idx = fesr_pkg::lowest_index(64'(first));

    always_comb
    begin
        syn_wdata = '0;
        for (int i = 0; i < RECORDS; i++)
        begin
            if (syn_idx == ID_W'(i))
            begin
                syn_wdata = {src[i], chk[i]};
            end
        end
    end

    fesr_syndrome_ram u_syndrome (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .wr_en_in(|first),
        .wr_addr_in(syn_idx),
        .wr_data_in(syn_wdata),
        .rd_addr_in(fm_idx),
        .rd_data_out(syn_rdata)
    );

    // Global summary: one bit per record valid
    logic [63:0] summary;

    assign summary = 64'(rec_valid);

    // Fault-manager port read word
    logic [DATA_W-1:0] fm_word;
    logic fm_syn_hit;

    always_comb
    begin
        fm_word = '0;
        fm_syn_hit = 1'b0;
        if (fm_rec_ok)
        begin
            for (int i = 0; i < RECORDS; i++)
            begin
                if (fm_idx == ID_W'(i))
                begin
                    if (fm_ofs == fesr_pkg::REC_CTL_OFS)
                    begin
                        fm_word[fesr_pkg::CTL_ED_BIT] = state_q.ctl[i].ed;
                        fm_word[fesr_pkg::CTL_UI_BIT] = state_q.ctl[i].ui;
                        fm_word[fesr_pkg::CTL_FI_BIT] = state_q.ctl[i].fi;
                        fm_word[fesr_pkg::CTL_CE_EN_BIT] = state_q.ctl[i].ce_en;
                    end
                    else if (fm_ofs == fesr_pkg::REC_STATUS_OFS)
                    begin
                        fm_word[fesr_pkg::STS_VALID_BIT] = state_q.sts[i].valid;
                        fm_word[fesr_pkg::STS_UE_BIT] = state_q.sts[i].ue;
                        fm_word[fesr_pkg::STS_REAL_UE_BIT] = state_q.sts[i].real_ue;
                    end
                    else if (fm_ofs == fesr_pkg::REC_SYND_OFS)
                    begin
                        // Syndrome of an invalid record reads as zero
                        fm_syn_hit = state_q.sts[i].valid;
                    end
                end
            end
        end
        else if (fm_bus_in.addr == fesr_pkg::GSR_LO_ADDR)
        begin
            fm_word = summary[31:0];
        end
        else if (fm_bus_in.addr == fesr_pkg::GSR_HI_ADDR)
        begin
            fm_word = summary[63:32];
        end
        else if (fm_bus_in.addr == fesr_pkg::LOCK_ADDR)
        begin
            fm_word[fesr_pkg::LOCK_BIT] = state_q.locked;
        end
    end

    // Main port read word; records are not decoded here
    logic [DATA_W-1:0] main_word;

    always_comb
    begin
        main_word = '0;
        if (main_bus_in.addr == fesr_pkg::MAIN_CFG_ADDR)
        begin
            main_word = state_q.cfg;
        end
        else if (main_bus_in.addr == fesr_pkg::MAIN_INFO_ADDR)
        begin
            main_word = DATA_W'(fesr_pkg::BUF_UNITS);
        end
    end

    // Next state
    always_comb
    begin
        state_d = state_q;
        state_d.sts = sts_next;
        state_d.ctl = ctl_next;
        if (fm_bus_in.wr && (fm_bus_in.addr == fesr_pkg::LOCK_ADDR))
        begin
            state_d.locked = (fm_bus_in.wdata != fesr_pkg::UNLOCK_KEY);
        end
        if (main_bus_in.wr && (main_bus_in.addr == fesr_pkg::MAIN_CFG_ADDR))
        begin
            state_d.cfg = main_bus_in.wdata;
        end
        state_d.fm_rdata = fm_bus_in.rd ? fm_word : '0;
        state_d.fm_syn_sel = fm_bus_in.rd && fm_syn_hit;
        state_d.main_rdata = main_bus_in.rd ? main_word : '0;
        if (fm_reset_in)
        begin
            state_d.ctl = '0;
            state_d.sts = '0;
        end
        if (reset_in)
        begin
            // Records are left alone so valid errors keep interrupting
            state_d.locked = 1'b1;
            state_d.cfg = fesr_pkg::MAIN_CFG_RESET;
            state_d.fm_rdata = '0;
            state_d.fm_syn_sel = 1'b0;
            state_d.main_rdata = '0;
        end
    end

    always_ff @(posedge clk_in)
    begin
        state_q <= state_d;
    end

    assign fm_rdata_out = state_q.fm_syn_sel ? DATA_W'(syn_rdata) : state_q.fm_rdata;
    assign main_rdata_out = state_q.main_rdata;
    assign locked_out = state_q.locked;

endmodule

/* inc/fesr_pkg.sv */
// Constants, register map and carrier types of the fault error record block.
// Assumes one clock; both resets are synchronous and active high.
package fesr_pkg;

    // Sizing
    localparam int BUF_UNITS = 8;
    localparam int RECORDS = BUF_UNITS + 2;
    localparam int ID_W = 6;
    localparam int CHK_W = 5;
    localparam int SRC_W = 3;
    localparam int SYN_W = SRC_W + CHK_W;
    localparam int CTL_CHECKS = 17;
    localparam int SIDE_CHANNELS = 16;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // Record numbering
    localparam int REC_CTL = 0;
    localparam int REC_SIDE = 1;
    localparam int REC_BUF_BASE = 2;

    // Checks that guard cache RAMs
    localparam logic [CHK_W-1:0] BUF_RAM_LO = 5'h07;
    localparam logic [CHK_W-1:0] BUF_RAM_HI = 5'h08;
    localparam logic [CHK_W-1:0] CTL_RAM_LO = 5'h07;
    localparam logic [CHK_W-1:0] CTL_RAM_HI = 5'h0a;
    localparam logic [CHK_W-1:0] UNKNOWN_CHECK = 5'h00;

    // Source codes kept in the syndrome
    localparam logic [SRC_W-1:0] SRC_CTL = 3'h0;
    localparam logic [SRC_W-1:0] SRC_SIDE = 3'h1;
    localparam logic [SRC_W-1:0] SRC_STREAM = 3'h2;
    localparam logic [SRC_W-1:0] SRC_WIRE = 3'h3;

    // Fault-manager port map: record n occupies 16 bytes at n * 16
    localparam logic [1:0] REC_AREA = 2'h0;
    localparam logic [3:0] REC_CTL_OFS = 4'h0;
    localparam logic [3:0] REC_STATUS_OFS = 4'h4;
    localparam logic [3:0] REC_SYND_OFS = 4'h8;
    localparam logic [ADDR_W-1:0] GSR_LO_ADDR = 12'h800;
    localparam logic [ADDR_W-1:0] GSR_HI_ADDR = 12'h804;
    localparam logic [ADDR_W-1:0] LOCK_ADDR = 12'h810;

    // Main port map
    localparam logic [ADDR_W-1:0] MAIN_CFG_ADDR = 12'h000;
    localparam logic [ADDR_W-1:0] MAIN_INFO_ADDR = 12'h004;
    localparam logic [DATA_W-1:0] MAIN_CFG_RESET = 32'h00000000;

    // Field positions
    localparam int CTL_ED_BIT = 0;
    localparam int CTL_UI_BIT = 2;
    localparam int CTL_FI_BIT = 3;
    localparam int CTL_CE_EN_BIT = 4;
    localparam int STS_REAL_UE_BIT = 28;
    localparam int STS_UE_BIT = 29;
    localparam int STS_VALID_BIT = 30;
    localparam int LOCK_BIT = 0;

    // Unlock key; the value is arbitrary
    localparam logic [DATA_W-1:0] UNLOCK_KEY = 32'h5afe0001;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } fesr_bus_req_s;

    typedef struct packed {
        logic valid;
        logic [ID_W-1:0] block_id;
        logic [CHK_W-1:0] check;
    } fesr_report_s;

    typedef struct packed {
        logic ce_en;
        logic fi;
        logic ui;
        logic ed;
    } fesr_rec_ctl_s;

    typedef struct packed {
        logic valid;
        logic ue;
        logic real_ue;
    } fesr_rec_sts_s;

    typedef struct packed {
        fesr_rec_ctl_s [RECORDS-1:0] ctl;
        fesr_rec_sts_s [RECORDS-1:0] sts;
        logic locked;
        logic [DATA_W-1:0] cfg;
        logic [DATA_W-1:0] fm_rdata;
        logic fm_syn_sel;
        logic [DATA_W-1:0] main_rdata;
    } fesr_state_s;

    typedef struct packed {
        logic [RECORDS-1:0][SYN_W-1:0] mem;
        logic [SYN_W-1:0] rdata;
    } fesr_ram_s;

    // Index of the lowest set bit, zero when none is set
    function automatic logic [ID_W-1:0] lowest_index(input logic [63:0] v);
        logic [ID_W-1:0] idx;
        idx = 6'h00;
        for (int i = 63; i >= 0; i--)
        begin
            if (v[i])
            begin
                idx = ID_W'(i);
            end
        end
        return idx;
    endfunction

    function automatic logic in_range(input logic [CHK_W-1:0] v, input logic [CHK_W-1:0] lo,
                                      input logic [CHK_W-1:0] hi);
        return (v >= lo) && (v <= hi);
    endfunction

endpackage

/* rtl/fesr_syndrome_ram.sv */
// Small memory with one syndrome entry per record; only the lowest record newly valid in a cycle gets its first-error syndrome.
// Assumes one write and one read per cycle; read data come out of a register.
`timescale 1ns/1ps
module fesr_syndrome_ram (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic wr_en_in,
    input wire logic [fesr_pkg::ID_W-1:0] wr_addr_in,
    input wire logic [fesr_pkg::SYN_W-1:0] wr_data_in,
    input wire logic [fesr_pkg::ID_W-1:0] rd_addr_in,
    output logic [fesr_pkg::SYN_W-1:0] rd_data_out
);

    localparam int ID_W = fesr_pkg::ID_W;

    fesr_pkg::fesr_ram_s state_q;
    fesr_pkg::fesr_ram_s state_d;

    always_comb
    begin
        state_d = state_q;
        if (wr_en_in && (wr_addr_in < ID_W'(fesr_pkg::RECORDS)))
        begin
            state_d.mem[wr_addr_in] = wr_data_in;
        end
        if (rd_addr_in < ID_W'(fesr_pkg::RECORDS))
        begin
            state_d.rdata = state_q.mem[rd_addr_in];
        end
        else
        begin
            state_d.rdata = '0;
        end
        if (reset_in)
        begin
            state_d.rdata = '0;
        end
    end

    always_ff @(posedge clk_in)
    begin
        state_q <= state_d;
    end

    assign rd_data_out = state_q.rdata;

endmodule

/* testbench/fesr_fault_records_chk.sv */
// Port-level checks of the fault record block.
// Assumes the bench pulses both resets before any traffic.
`timescale 1ns/1ps
module fesr_fault_records_chk (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic fm_reset_in,
    input wire fesr_pkg::fesr_bus_req_s fm_bus_in,
    input wire logic [fesr_pkg::DATA_W-1:0] fm_rdata_out,
    input wire fesr_pkg::fesr_bus_req_s main_bus_in,
    input wire logic [fesr_pkg::DATA_W-1:0] main_rdata_out,
    input wire fesr_pkg::fesr_report_s stream_report_in,
    input wire logic [fesr_pkg::BUF_UNITS-1:0] buf_err_wire_in,
    input wire logic [fesr_pkg::CTL_CHECKS-1:0] ctl_check_in,
    input wire logic [fesr_pkg::SIDE_CHANNELS-1:0] side_err_in,
    input wire logic recovery_interrupt_out,
    input wire logic fault_handling_interrupt_out,
    input wire logic [fesr_pkg::RECORDS-1:0] unit_err_out,
    input wire logic locked_out
);
    logic any_err;
    assign any_err = stream_report_in.valid || (|buf_err_wire_in) || (|ctl_check_in) || (|side_err_in);
    sequence s_info_rd;
        main_bus_in.rd && main_bus_in.addr == fesr_pkg::MAIN_INFO_ADDR;
    endsequence
    sequence s_hole_rd;
        fm_bus_in.rd && fm_bus_in.addr >= fesr_pkg::RECORDS * 16 && fm_bus_in.addr < fesr_pkg::GSR_LO_ADDR;
    endsequence
    sequence s_key_wr;
        fm_bus_in.wr && fm_bus_in.addr == fesr_pkg::LOCK_ADDR;
    endsequence
    a_fm_rst_clear: assert property (@(posedge clk_in) disable iff (reset_in)
        fm_reset_in |=> !recovery_interrupt_out && !fault_handling_interrupt_out && unit_err_out == '0)
        else $error("records not cleared by fault-manager reset");
    a_lock_after_rst: assert property (@(posedge clk_in) disable iff (fm_reset_in)
        reset_in |=> locked_out) else $error("register file unlocked after reset");
    a_lock_key_effect: assert property (@(posedge clk_in) disable iff (reset_in)
        s_key_wr |=> locked_out == ($past(fm_bus_in.wdata) != fesr_pkg::UNLOCK_KEY)) else $error("lock state wrong");
    a_fm_rd_idle: assert property (@(posedge clk_in) disable iff (reset_in)
        !fm_bus_in.rd |=> fm_rdata_out == '0) else $error("fm read data without read");
    a_main_rd_idle: assert property (@(posedge clk_in) disable iff (reset_in)
        !main_bus_in.rd |=> main_rdata_out == '0) else $error("main read data without read");
    a_info_units: assert property (@(posedge clk_in) disable iff (reset_in)
        s_info_rd |=> main_rdata_out == fesr_pkg::BUF_UNITS) else $error("unit count wrong");
    a_hole_zero: assert property (@(posedge clk_in) disable iff (reset_in)
        s_hole_rd |=> fm_rdata_out == '0) else $error("unused record not zero");
    a_fault_cause: assert property (@(posedge clk_in) disable iff (fm_reset_in)
        $rose(fault_handling_interrupt_out) |-> $past(any_err || fm_bus_in.wr)) else $error("fault irq uncaused");
    a_rec_cause: assert property (@(posedge clk_in) disable iff (fm_reset_in)
        $rose(recovery_interrupt_out) |-> $past(any_err || fm_bus_in.wr)) else $error("recovery irq uncaused");
    a_unit_err_hold: assert property (@(posedge clk_in) disable iff (fm_reset_in)
        !fm_bus_in.wr && !fm_reset_in |=> (unit_err_out & $past(unit_err_out)) == $past(unit_err_out))
        else $error("unit error dropped without clear");
    a_unit_err_cause: assert property (@(posedge clk_in) disable iff (fm_reset_in)
        (unit_err_out & ~$past(unit_err_out)) != '0 |-> $past(any_err)) else $error("unit error uncaused");
endmodule
bind fesr_fault_records fesr_fault_records_chk u_fesr_fault_records_chk (.clk_in, .reset_in, .fm_reset_in,
    .fm_bus_in, .fm_rdata_out, .main_bus_in, .main_rdata_out, .stream_report_in, .buf_err_wire_in,
    .ctl_check_in, .side_err_in, .recovery_interrupt_out, .fault_handling_interrupt_out, .unit_err_out,
    .locked_out);

/* testbench/fesr_unit_model.sv */
// Behavioural buffer units: stream reports and held error wires.
// Assumes one report command at a time, synchronous to clk_in.
`timescale 1ns/1ps
module fesr_unit_model (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic send_in,
    input wire logic [fesr_pkg::ID_W-1:0] id_in,
    input wire logic [fesr_pkg::CHK_W-1:0] check_in,
    input wire logic [fesr_pkg::BUF_UNITS-1:0] clear_in,
    output fesr_pkg::fesr_report_s report_out,
    output logic [fesr_pkg::BUF_UNITS-1:0] wire_out
);
    logic ram;
    logic [fesr_pkg::BUF_UNITS-1:0] hit;
    assign ram = (check_in >= fesr_pkg::BUF_RAM_LO) && (check_in <= fesr_pkg::BUF_RAM_HI);
    assign hit = (send_in && !ram) ? fesr_pkg::BUF_UNITS'(1) << (id_in - 6'h02) : '0;
    always_ff @(posedge clk_in)
    begin
        report_out.valid <= send_in;
        // Idle fields toggle so a stale value is never mistaken for a report
        report_out.block_id <= send_in ? id_in : ~report_out.block_id;
        report_out.check <= send_in ? check_in : ~report_out.check;
        if (reset_in)
            wire_out <= '0;
        else
            wire_out <= (wire_out & ~clear_in) | hit;
    end
endmodule

/* testbench/tb.sv */
// Self-checking bench of the fault record block with a buffer-unit model.
// Assumes a 125 MHz clock and synchronous active-high resets.
`timescale 1ns/1ps
module tb;
    logic clk_in, reset_in, fm_reset_in, rec_irq, flt_irq, locked, send;
    fesr_pkg::fesr_bus_req_s fm_bus, main_bus;
    fesr_pkg::fesr_report_s report;
    logic [31:0] fm_rdata, main_rdata;
    logic [7:0] wire_lv, clr;
    logic [16:0] ctl_chk;
    logic [15:0] side;
    logic [9:0] unit_err;
    logic [5:0] sid;
    logic [4:0] schk;
    int err_count, checks_done;
    fesr_fault_records u_fesr_fault_records (.clk_in(clk_in), .reset_in(reset_in), .fm_reset_in(fm_reset_in),
        .fm_bus_in(fm_bus), .fm_rdata_out(fm_rdata), .main_bus_in(main_bus), .main_rdata_out(main_rdata),
        .stream_report_in(report), .buf_err_wire_in(wire_lv), .ctl_check_in(ctl_chk), .side_err_in(side),
        .recovery_interrupt_out(rec_irq), .fault_handling_interrupt_out(flt_irq), .unit_err_out(unit_err),
        .locked_out(locked));
    fesr_unit_model u_fesr_unit_model (.clk_in(clk_in), .reset_in(reset_in), .send_in(send), .id_in(sid),
        .check_in(schk), .clear_in(clr), .report_out(report), .wire_out(wire_lv));
    initial
    begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end
    task automatic finish_test;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic flags(input logic [11:0] e);
        chk("irq_unit", {20'h0, e}, {20'h0, rec_irq, flt_irq, unit_err});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    function automatic logic [11:0] ra(input int n, input int o);
        return 12'(n * 16 + o);
    endfunction
    task automatic wr(input logic m, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_in);
        if (m)
            main_bus <= '{a, d, 1'b1, 1'b0};
        else
            fm_bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_in);
        main_bus.wr <= 1'b0;
        fm_bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic m, input logic [11:0] a, input logic [31:0] e);
        @(posedge clk_in);
        if (m)
            main_bus <= '{a, 32'h0, 1'b0, 1'b1};
        else
            fm_bus <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk_in);
        main_bus.rd <= 1'b0;
        fm_bus.rd <= 1'b0;
        #1;
        chk($sformatf("read %h", a), e, m ? main_rdata : fm_rdata);
    endtask
    task automatic unit_send(input logic [5:0] id, input logic [4:0] c);
        @(posedge clk_in);
        send <= 1'b1;
        sid <= id;
        schk <= c;
        @(posedge clk_in);
        send <= 1'b0;
        cyc(2);
    endtask
    task automatic clr_wire(input logic [7:0] m);
        @(posedge clk_in);
        clr <= m;
        @(posedge clk_in);
        clr <= 8'h00;
    endtask
    task automatic t_start;
        chk("locked", 32'h1, {31'h0, locked});
        flags(12'h000);
        rd(0, ra(2, 0), 32'h0);
        rd(0, fesr_pkg::GSR_LO_ADDR, 32'h0);
        wr(0, fesr_pkg::LOCK_ADDR, fesr_pkg::UNLOCK_KEY);
        cyc(1);
        chk("unlocked", 32'h0, {31'h0, locked});
    endtask
    task automatic t_buf;
        wr(0, ra(2, 0), 32'h0000000d);
        unit_send(6'h02, 5'h03);
        rd(0, ra(2, 4), 32'h70000000);
        flags(12'hc04);
        rd(0, fesr_pkg::GSR_LO_ADDR, 32'h4);
        chk("wire", 32'h1, {24'h0, wire_lv});
        clr_wire(8'h01);
        wr(0, ra(2, 4), 32'h40000000);
        cyc(1);
        flags(12'h000);
    endtask
    task automatic t_ram;
        wr(0, ra(3, 0), 32'h0000000d);
        unit_send(6'h03, 5'h07);
        rd(0, ra(3, 4), 32'h40000000);
        flags(12'h400);
        chk("wire", 32'h0, {24'h0, wire_lv});
        wr(0, ra(3, 4), 32'h40000000);
        wr(0, ra(3, 0), 32'h0000001d);
        unit_send(6'h03, 5'h08);
        rd(0, ra(3, 4), 32'h60000000);
        flags(12'hc00);
        wr(0, ra(3, 4), 32'h40000000);
    endtask
    task automatic t_detect;
        unit_send(6'h04, 5'h02);
        cyc(1);
        rd(0, ra(4, 4), 32'h0);
        flags(12'h000);
        clr_wire(8'h04);
    endtask
    task automatic t_ctl_side;
        wr(0, ra(0, 0), 32'h9);
        wr(0, ra(1, 0), 32'h9);
        @(posedge clk_in);
        ctl_chk <= 17'h01000;
        @(posedge clk_in);
        ctl_chk <= 17'h0;
        side <= 16'h8000;
        @(posedge clk_in);
        side <= 16'h0;
        rd(0, ra(0, 4), 32'h70000000);
        rd(0, ra(0, 8), 32'h0c);
        rd(0, ra(1, 4), 32'h70000000);
        rd(0, ra(1, 8), 32'h2f);
        flags(12'h403);
    endtask
    task automatic t_map;
        wr(0, ra(10, 0), 32'hd);
        rd(0, ra(10, 0), 32'h0);
        rd(1, ra(1, 4), 32'h0);
        rd(1, fesr_pkg::MAIN_INFO_ADDR, 32'h8);
        wr(1, fesr_pkg::MAIN_CFG_ADDR, 32'ha5a50f0f);
        rd(1, fesr_pkg::MAIN_CFG_ADDR, 32'ha5a50f0f);
    endtask
    task automatic t_freset;
        @(posedge clk_in);
        reset_in <= 1'b1;
        cyc(2);
        flags(12'h403);
        @(posedge clk_in);
        reset_in <= 1'b0;
        cyc(1);
        flags(12'h403);
        chk("locked", 32'h1, {31'h0, locked});
        rd(1, fesr_pkg::MAIN_CFG_ADDR, fesr_pkg::MAIN_CFG_RESET);
        wr(0, ra(0, 4), 32'h40000000);
        rd(0, ra(0, 4), 32'h70000000);
        unit_send(6'h02, 5'h05);
        rd(0, ra(2, 4), 32'h70000000);
        flags(12'hc07);
    endtask
    task automatic t_fmreset;
        clr_wire(8'h01);
        wr(1, fesr_pkg::MAIN_CFG_ADDR, 32'h0000003c);
        @(posedge clk_in);
        fm_reset_in <= 1'b1;
        @(posedge clk_in);
        fm_reset_in <= 1'b0;
        cyc(1);
        flags(12'h000);
        rd(0, fesr_pkg::GSR_LO_ADDR, 32'h0);
        rd(0, ra(2, 0), 32'h0);
        chk("locked", 32'h1, {31'h0, locked});
        rd(1, fesr_pkg::MAIN_CFG_ADDR, 32'h0000003c);
    endtask
    initial
    begin
        #20000;
        err_count++;
        finish_test;
    end
    initial
    begin
        err_count = 0;
        checks_done = 0;
        reset_in = 1'b1;
        fm_reset_in = 1'b1;
        fm_bus = '0;
        main_bus = '0;
        ctl_chk = '0;
        side = '0;
        clr = '0;
        send = 1'b0;
        sid = '0;
        schk = '0;
        repeat (12) @(posedge clk_in);
        reset_in <= 1'b0;
        fm_reset_in <= 1'b0;
        cyc(1);
        t_start;
        t_buf;
        t_ram;
        t_detect;
        t_ctl_side;
        t_map;
        t_freset;
        t_fmreset;
        finish_test;
    end
endmodule
